// [design/atm_sar_pkg.sv]
// constants, field layouts and carrier types of the cell segmentation core
// assumes one core clock; the receive phy clock arrives as a sampled pin
package atm_sar_pkg;
	// word and cell geometry
	localparam int WORD_W = 32;
	localparam int CM_AW = 14;
	localparam int CELL_WORDS = 13;
	localparam int PAY_WORDS = 12;
	localparam int CELL_BYTES = 53;
	localparam int HDR_BYTES = 4;
	localparam int HEC_POS = 4;
	localparam int BURST_ALIGNED = 12;
	localparam int BURST_MAX = 13;
	// buffer depths in cells
	localparam int TX_CELLS_DEF = 8;
	localparam int RX_CELLS_DEF = 32;
	// bus latency the receive buffer must ride out
	localparam int LAT_NS = 30000;
	localparam int LINE_KBPS = 155520;
	localparam int CELL_NS = (CELL_BYTES * 8 * 1000000) / LINE_KBPS;
	localparam int LAT_CELLS = (LAT_NS + CELL_NS - 1) / CELL_NS;
	// local bus write strobe width in clock cycles
	localparam int LB_CS_CYCLES = 8;
	// circuit space
	localparam logic [15:0] VC_MAX = 16'h03ff;
	// control memory map
	localparam int BWG_SLOTS = 8192;
	localparam logic [CM_AW-1:0] BWG_BASE = 14'h0000;
	localparam logic [CM_AW-1:0] TX_HDR_BASE = 14'h2000;
	localparam logic [CM_AW-1:0] RX_DMA_BASE = 14'h3000;
	localparam int BWG_VALID_BIT = 31;
	// arbiter requester indices, highest priority first
	localparam int NUM_REQ = 6;
	localparam int REQ_RX_ADAPT = 0;
	localparam int REQ_TX_ADAPT = 1;
	localparam int REQ_SCHED = 2;
	localparam int REQ_RX_HOST = 3;
	localparam int REQ_TX_HOST = 4;
	localparam int REQ_BRIDGE = 5;
	// cell header fields and fills
	localparam logic [31:0] IDLE_HDR = 32'h00000001;
	localparam logic [7:0] HEC_FILL = 8'h00;
	localparam int PTI_END_BIT = 1;
	localparam int ST_EOM_BIT = 30;
	// packet check
	localparam logic [31:0] CRC_POLY = 32'h04c11db7;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam logic [31:0] CRC_GOOD = 32'h00000000;

	typedef struct packed {
		logic we;
		logic [CM_AW-1:0] addr;
		logic [WORD_W-1:0] wdata;
	} cm_req_t;

	typedef struct packed {
		logic first;
		logic [WORD_W-1:0] data;
	} cell_word_t;

	typedef struct packed {
		logic [WORD_W-1:0] data;
		logic [9:0] vci;
		logic last;
		logic crc_ok;
	} rx_out_t;

	typedef struct packed {
		logic clk;
		logic soc;
		logic empty_n;
		logic [7:0] data;
	} phy_rx_pins_t;

	typedef enum {T_IDLE, T_BWG, T_HDR, T_DATA, T_FILL} tx_state_t;
	typedef enum {R_IDLE, R_LOOK, R_DATA, R_WB} rx_state_t;
endpackage

// [design/atm_cell_sar_core.sv]
// cell segmentation and reassembly core: tx path, rx path, control memory arbiter, local bus write
// assumes host-side logic on core_clk; phy pins and phy clock are asynchronous and synchronised here
// Functional notes
// - local bus write holds phy chip select low exactly eight clocks
// - host burst is 12 words, 13 when payload is not word aligned
// - receive buffering covers 30 us of host bus latency
// - host side carries 48 payload bytes, phy side 53-byte cells
// - scheduler walks a large bandwidth table for fine per-group rates
// - a circuit keeps its slots until its whole packet is sent
// - receive accepts circuit ids up to 1023, others dropped
// - aal3/4 mode moves 48-byte units and detects end of message
// - byte-wide cell interface each way, receive timed by phy clock
// - core runs on one clock with 32-bit words
// - transmit side requests 48-byte transfers from host bus unit
// - scheduler reads bandwidth table to pick the next circuit
// - transmit adaptation prepends a four-byte header per cell
// - transmit computes packet crc and appends it
// - transmit buffer holds 8 cells of 13 words, idle cells too
// - transmit phy side unpacks words to bytes on core clock
// - receive phy side packs bytes to words and drops idle cells
// - receive buffer holds 32 cells and moves them to core timing
// - receive adaptation checks crc and flags end of packet
// - receive header removed and used to find circuit entry
// - control memory single-word grants in fixed priority order
// - reads drive address with output enable, data taken on its rise
module atm_cell_sar_core import atm_sar_pkg::*; #(
	parameter int TX_CELLS = TX_CELLS_DEF,
	parameter int RX_CELLS = RX_CELLS_DEF
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// host transmit side
	input wire logic host_tx_pending,
	input wire logic host_tx_last,
	input wire logic host_tx_misaligned,
	input wire logic host_tx_valid,
	input wire logic [WORD_W-1:0] host_tx_data,
	output logic host_tx_ready,
	output logic host_xfer_req,
	output logic [3:0] host_xfer_words,
	// host receive side
	input wire logic aal34_mode,
	input wire logic rx_host_ready,
	output logic rx_host_valid,
	output rx_out_t rx_host_out,
	// external control memory requesters
	input wire logic [2:0] ext_cm_req,
	input wire cm_req_t ext_cm_rxh,
	input wire cm_req_t ext_cm_txh,
	input wire cm_req_t ext_cm_brg,
	output logic [2:0] ext_cm_done,
	output logic [WORD_W-1:0] cm_rd_data,
	// control memory pins
	output logic [CM_AW-1:0] ctrl_mem_address,
	input wire logic [WORD_W-1:0] ctrl_mem_data_in,
	output logic [WORD_W-1:0] ctrl_mem_data_out,
	output logic ctrl_mem_data_oe,
	output logic ctrl_mem_output_enable_n,
	output logic ctrl_mem_write_strobe_n,
	// local bus write
	input wire logic lb_wr_valid,
	input wire logic [15:0] lb_wr_addr,
	input wire logic [7:0] lb_wr_data,
	output logic lb_wr_ready,
	output logic phy_local_chip_select_n,
	output logic [15:0] lb_addr,
	output logic [7:0] lb_data,
	// transmit phy
	input wire logic tx_phy_full_n,
	output logic [7:0] tx_phy_data,
	output logic tx_phy_soc,
	output logic tx_phy_enable_n,
	// receive phy
	input wire phy_rx_pins_t rx_phy_pins
);
	localparam int TX_DEPTH = TX_CELLS * CELL_WORDS;
	localparam int RX_DEPTH = RX_CELLS * CELL_WORDS;
	localparam int TXA = $clog2(TX_DEPTH + 1);
	localparam int RXA = $clog2(RX_DEPTH + 1);

	// msb-first crc over one word
	function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 31; i >= 0; i--) begin
			r = (r[31] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	// lowest index set wins
	function automatic logic [2:0] first_req(input logic [NUM_REQ-1:0] r);
		logic [2:0] k;
		k = 3'd0;
		for (int i = NUM_REQ - 1; i >= 0; i--) begin
			if (r[i]) k = 3'(i);
		end
		return k;
	endfunction

	// pin synchronisers
	phy_rx_pins_t rxs1_q, rxs2_q;
	logic full1_q, full2_q, rxclk_prev_q;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rxs1_q <= '0;
			rxs2_q <= '0;
			full1_q <= 1'b0;
			full2_q <= 1'b0;
			rxclk_prev_q <= 1'b0;
		end else begin
			rxs1_q <= rx_phy_pins;
			rxs2_q <= rxs1_q;
			full1_q <= tx_phy_full_n;
			full2_q <= full1_q;
			rxclk_prev_q <= rxs2_q.clk;
		end
	end

	// control memory arbiter
	logic [NUM_REQ-1:0] req_vec, cm_done_q;
	cm_req_t cmd_arr [NUM_REQ];
	cm_req_t cur_q;
	logic [2:0] gnt_q, gnt_d;
	logic cm_act_q, oe_n_q, we_n_q, doe_q;
	logic [WORD_W-1:0] cm_rd_q;
	assign gnt_d = first_req(req_vec);
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cm_done_q <= '0;
			cur_q <= '0;
			gnt_q <= 3'd0;
			cm_act_q <= 1'b0;
			oe_n_q <= 1'b1;
			we_n_q <= 1'b1;
			doe_q <= 1'b0;
			cm_rd_q <= '0;
		end else begin
			cm_done_q <= '0;
			// write data still driven as the strobe rises, released one cycle later
			if (cm_done_q != '0) doe_q <= 1'b0;
			if (cm_act_q) begin
				cm_act_q <= 1'b0;
				oe_n_q <= 1'b1;
				we_n_q <= 1'b1;
				cm_done_q[gnt_q] <= 1'b1;
				if (!cur_q.we) cm_rd_q <= ctrl_mem_data_in; // taken as output enable rises
			end else if (cm_done_q == '0 && req_vec != '0) begin
				gnt_q <= gnt_d; // fixed priority, one word per grant
				cur_q <= cmd_arr[gnt_d];
				cm_act_q <= 1'b1;
				oe_n_q <= cmd_arr[gnt_d].we;
				we_n_q <= !cmd_arr[gnt_d].we;
				doe_q <= cmd_arr[gnt_d].we;
			end
		end
	end
	assign ctrl_mem_address = cur_q.addr;
	assign ctrl_mem_data_out = cur_q.wdata;
	assign ctrl_mem_data_oe = doe_q;
	assign ctrl_mem_output_enable_n = oe_n_q;
	assign ctrl_mem_write_strobe_n = we_n_q;
	assign ext_cm_done = cm_done_q[REQ_BRIDGE:REQ_RX_HOST];
	assign cm_rd_data = cm_rd_q;

	// local bus write strobe
	logic [3:0] lb_cnt_q;
	logic lb_cs_n_q;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			lb_cnt_q <= 4'd0;
			lb_cs_n_q <= 1'b1;
			lb_addr <= '0;
			lb_data <= '0;
		end else if (lb_cs_n_q && lb_wr_valid) begin
			lb_addr <= lb_wr_addr;
			lb_data <= lb_wr_data;
			lb_cs_n_q <= 1'b0;
			lb_cnt_q <= 4'(LB_CS_CYCLES - 1);
		end else if (!lb_cs_n_q) begin
			if (lb_cnt_q == 4'd0) lb_cs_n_q <= 1'b1; // low for exactly eight clocks
			else lb_cnt_q <= lb_cnt_q - 4'd1;
		end
	end
	assign lb_wr_ready = lb_cs_n_q;
	assign phy_local_chip_select_n = lb_cs_n_q;

	// transmit buffer storage
	cell_word_t tx_mem [TX_DEPTH]; // 32-bit words on the one core clock
	logic [TXA-1:0] txw_q, txr_q, tx_cnt_q;
	logic [3:0] tx_cells_q;
	logic txf_wr, txf_rd, txf_cell_in, txf_cell_out;
	cell_word_t txf_wdata;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			txw_q <= '0;
			txr_q <= '0;
			tx_cnt_q <= '0;
			tx_cells_q <= '0;
		end else begin
			if (txf_wr) txw_q <= (txw_q == TXA'(TX_DEPTH - 1)) ? '0 : txw_q + 1'b1;
			if (txf_rd) txr_q <= (txr_q == TXA'(TX_DEPTH - 1)) ? '0 : txr_q + 1'b1;
			tx_cnt_q <= tx_cnt_q + TXA'(txf_wr) - TXA'(txf_rd);
			tx_cells_q <= tx_cells_q + 4'(txf_cell_in) - 4'(txf_cell_out); // idle cells counted alike
		end
	end
	always_ff @(posedge core_clk) begin
		if (txf_wr) tx_mem[txw_q] <= txf_wdata;
	end

	// scheduler, adaptation and host transaction sequencing
	tx_state_t tx_st_q;
	logic [12:0] slot_q;
	logic [9:0] tx_vc_q;
	logic [3:0] tx_wc_q;
	logic pkt_active_q, last_q;
	logic [31:0] tx_crc_q;
	logic tx_crc_word;
	assign host_tx_ready = (tx_st_q == T_DATA);
	assign tx_crc_word = last_q && tx_wc_q == 4'(PAY_WORDS - 1);
	always_comb begin
		txf_wr = 1'b0;
		txf_wdata = '0;
		if (tx_st_q == T_BWG && cm_done_q[REQ_SCHED] && !(cm_rd_q[BWG_VALID_BIT] && (pkt_active_q || host_tx_pending))) begin
			txf_wr = 1'b1;
			txf_wdata = '{first: 1'b1, data: IDLE_HDR};
		end else if (tx_st_q == T_HDR && cm_done_q[REQ_TX_ADAPT]) begin
			txf_wr = 1'b1; // four header bytes ahead of each payload
			txf_wdata = '{first: 1'b1, data: {cm_rd_q[31:2], host_tx_last, cm_rd_q[0]}};
		end else if (tx_st_q == T_DATA && host_tx_valid) begin
			txf_wr = 1'b1;
			txf_wdata = '{first: 1'b0, data: tx_crc_word ? tx_crc_q : host_tx_data}; // crc appended
		end else if (tx_st_q == T_FILL) begin
			txf_wr = 1'b1;
		end
	end
	assign txf_cell_in = txf_wr && !txf_wdata.first && tx_wc_q == 4'(PAY_WORDS - 1);
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tx_st_q <= T_IDLE;
			slot_q <= '0;
			tx_vc_q <= '0;
			tx_wc_q <= '0;
			pkt_active_q <= 1'b0;
			last_q <= 1'b0;
			tx_crc_q <= CRC_INIT;
			host_xfer_req <= 1'b0;
			host_xfer_words <= '0;
		end else begin
			host_xfer_req <= 1'b0;
			case (tx_st_q)
				T_IDLE: begin
					tx_wc_q <= '0;
					if (tx_cnt_q <= TXA'(TX_DEPTH - CELL_WORDS)) tx_st_q <= T_BWG;
				end
				T_BWG: if (cm_done_q[REQ_SCHED]) begin
					slot_q <= slot_q + 13'd1; // one table slot per cell time
					if (cm_rd_q[BWG_VALID_BIT] && (pkt_active_q || host_tx_pending)) begin
						if (!pkt_active_q) tx_vc_q <= cm_rd_q[9:0]; // circuit kept until packet ends
						tx_st_q <= T_HDR;
					end else begin
						tx_st_q <= T_FILL;
					end
				end
				T_HDR: if (cm_done_q[REQ_TX_ADAPT]) begin
					last_q <= host_tx_last;
					pkt_active_q <= 1'b1;
					if (!pkt_active_q) tx_crc_q <= CRC_INIT;
					host_xfer_req <= 1'b1; // one 48-byte payload per request
					host_xfer_words <= host_tx_misaligned ? 4'(BURST_MAX) : 4'(BURST_ALIGNED);
					tx_st_q <= T_DATA;
				end
				T_DATA: if (host_tx_valid) begin
					if (!tx_crc_word) tx_crc_q <= crc_word(tx_crc_q, host_tx_data);
					tx_wc_q <= tx_wc_q + 4'd1;
					if (tx_wc_q == 4'(PAY_WORDS - 1)) begin
						pkt_active_q <= !last_q;
						tx_st_q <= T_IDLE;
					end
				end
				T_FILL: begin
					tx_wc_q <= tx_wc_q + 4'd1;
					if (tx_wc_q == 4'(PAY_WORDS - 1)) tx_st_q <= T_IDLE;
				end
				default: tx_st_q <= T_IDLE;
			endcase
		end
	end

	// transmit phy: word to byte unpacking on the core clock
	logic [5:0] txb_q, txk;
	logic tx_go;
	cell_word_t tx_head;
	assign tx_head = tx_mem[txr_q];
	assign txk = txb_q - 6'(HEC_POS + 1);
	assign tx_go = (txb_q != '0 || tx_cells_q != '0) && full2_q;
	assign txf_rd = tx_go && (txb_q == 6'(HDR_BYTES - 1) || (txb_q > 6'(HEC_POS) && txk[1:0] == 2'd3));
	assign txf_cell_out = tx_go && txb_q == 6'(CELL_BYTES - 1);
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			txb_q <= '0;
			tx_phy_data <= '0;
			tx_phy_soc <= 1'b0;
			tx_phy_enable_n <= 1'b1;
		end else begin
			tx_phy_enable_n <= !tx_go;
			tx_phy_soc <= tx_go && txb_q == '0;
			if (tx_go) begin
				txb_q <= (txb_q == 6'(CELL_BYTES - 1)) ? '0 : txb_q + 6'd1;
				if (txb_q < 6'(HDR_BYTES)) tx_phy_data <= tx_head.data[8*(3-txb_q[1:0]) +: 8];
				else if (txb_q == 6'(HEC_POS)) tx_phy_data <= HEC_FILL;
				else tx_phy_data <= tx_head.data[8*(3-txk[1:0]) +: 8];
			end
		end
	end

	// receive phy: byte to word packing, idle and foreign cells dropped
	cell_word_t rx_mem [RX_DEPTH];
	logic [RXA-1:0] rxw_q, rxr_q, rx_cnt_q;
	logic [5:0] rx_cells_q, rxb_q, rxp, rxk;
	logic rx_en, rx_in_q, rx_drop_q, rx_hdr_bad, rxf_wr, rxf_rd, rx_cell_out;
	logic [31:0] rx_sh_q, rx_sh_d;
	assign rx_en = rxs2_q.clk && !rxclk_prev_q && rxs2_q.empty_n; // sampled phy clock edge
	assign rxp = rxs2_q.soc ? '0 : rxb_q;
	assign rxk = rxp - 6'(HEC_POS + 1);
	assign rx_sh_d = {rx_sh_q[23:0], rxs2_q.data};
	assign rx_hdr_bad = rx_sh_d[31:4] == '0 || rx_sh_d[19:4] > VC_MAX
		|| rx_cnt_q > RXA'(RX_DEPTH - CELL_WORDS);
	assign rxf_wr = rx_en && (rxs2_q.soc || rx_in_q) && ((rxp == 6'(HDR_BYTES - 1) && !rx_hdr_bad)
		|| (rxp > 6'(HEC_POS) && rxk[1:0] == 2'd3 && !rx_drop_q));
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rxb_q <= '0;
			rx_in_q <= 1'b0;
			rx_drop_q <= 1'b0;
			rx_sh_q <= '0;
		end else if (rx_en && (rxs2_q.soc || rx_in_q)) begin
			rx_sh_q <= rx_sh_d;
			rxb_q <= rxp + 6'd1;
			rx_in_q <= rxp != 6'(CELL_BYTES - 1);
			if (rxp == 6'(HDR_BYTES - 1)) rx_drop_q <= rx_hdr_bad;
		end
	end
	always_ff @(posedge core_clk) begin
		if (rxf_wr) rx_mem[rxw_q] <= '{first: rxp == 6'(HDR_BYTES - 1), data: rx_sh_d};
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rxw_q <= '0;
			rxr_q <= '0;
			rx_cnt_q <= '0;
			rx_cells_q <= '0;
		end else begin
			if (rxf_wr) rxw_q <= (rxw_q == RXA'(RX_DEPTH - 1)) ? '0 : rxw_q + 1'b1;
			if (rxf_rd) rxr_q <= (rxr_q == RXA'(RX_DEPTH - 1)) ? '0 : rxr_q + 1'b1;
			rx_cnt_q <= rx_cnt_q + RXA'(rxf_wr) - RXA'(rxf_rd); // cells cross into core timing
			rx_cells_q <= rx_cells_q + 6'(rxf_wr && rxp == 6'(CELL_BYTES - 1)) - 6'(rx_cell_out);
		end
	end

	// receive header and adaptation processing
	rx_state_t rx_st_q;
	logic [31:0] rx_hdr_q, rx_crc_q, rx_crc_d, rx_word;
	logic [3:0] rx_wc_q;
	logic rx_eom_q, rx_last_cell, ob_in_ready, ob_push;
	rx_out_t ob_in;
	assign rx_word = rx_mem[rxr_q].data;
	assign rx_crc_d = crc_word(rx_crc_q, rx_word);
	assign rx_last_cell = aal34_mode ? ((rx_wc_q == '0) ? rx_word[ST_EOM_BIT] : rx_eom_q) : rx_hdr_q[PTI_END_BIT];
	assign ob_push = rx_st_q == R_DATA && ob_in_ready;
	assign rxf_rd = (rx_st_q == R_IDLE && rx_cells_q != '0) || ob_push;
	assign rx_cell_out = ob_push && rx_wc_q == 4'(PAY_WORDS - 1);
	always_comb begin
		ob_in.data = rx_word;
		ob_in.vci = rx_hdr_q[13:4];
		ob_in.last = rx_last_cell && rx_wc_q == 4'(PAY_WORDS - 1);
		ob_in.crc_ok = aal34_mode || rx_crc_d == CRC_GOOD;
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rx_st_q <= R_IDLE;
			rx_hdr_q <= '0;
			rx_crc_q <= CRC_INIT;
			rx_wc_q <= '0;
			rx_eom_q <= 1'b0;
		end else begin
			case (rx_st_q)
				R_IDLE: if (rx_cells_q != '0) begin
					rx_hdr_q <= rx_word; // header stripped here
					rx_st_q <= R_LOOK;
				end
				R_LOOK: if (cm_done_q[REQ_RX_ADAPT]) begin
					rx_crc_q <= cm_rd_q;
					rx_wc_q <= '0;
					rx_st_q <= R_DATA;
				end
				R_DATA: if (ob_in_ready) begin
					if (rx_wc_q == '0) rx_eom_q <= rx_word[ST_EOM_BIT];
					rx_crc_q <= (ob_in.last) ? CRC_INIT : rx_crc_d;
					rx_wc_q <= rx_wc_q + 4'd1;
					if (rx_wc_q == 4'(PAY_WORDS - 1)) rx_st_q <= R_WB;
				end
				R_WB: if (cm_done_q[REQ_RX_ADAPT]) rx_st_q <= R_IDLE;
				default: rx_st_q <= R_IDLE;
			endcase
		end
	end

	// requester commands
	always_comb begin
		req_vec = {ext_cm_req[2:0], tx_st_q == T_BWG, tx_st_q == T_HDR, rx_st_q == R_LOOK || rx_st_q == R_WB};
		cmd_arr[REQ_RX_ADAPT] = '{we: rx_st_q == R_WB, addr: RX_DMA_BASE + CM_AW'(rx_hdr_q[13:4]), wdata: rx_crc_q};
		cmd_arr[REQ_TX_ADAPT] = '{we: 1'b0, addr: TX_HDR_BASE + CM_AW'(tx_vc_q), wdata: '0};
		cmd_arr[REQ_SCHED] = '{we: 1'b0, addr: BWG_BASE + CM_AW'(slot_q), wdata: '0};
		cmd_arr[REQ_RX_HOST] = ext_cm_rxh;
		cmd_arr[REQ_TX_HOST] = ext_cm_txh;
		cmd_arr[REQ_BRIDGE] = ext_cm_brg;
	end

	// two-entry output buffer toward the host
	rx_out_t ob_mem [2];
	logic ob_wp_q, ob_rp_q;
	logic [1:0] ob_cnt_q;
	logic ob_pop;
	assign ob_in_ready = ob_cnt_q != 2'd2;
	assign ob_pop = rx_host_valid && rx_host_ready;
	assign rx_host_valid = ob_cnt_q != 2'd0;
	assign rx_host_out = ob_mem[ob_rp_q];
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ob_mem[0] <= '0;
			ob_mem[1] <= '0;
			ob_wp_q <= 1'b0;
			ob_rp_q <= 1'b0;
			ob_cnt_q <= 2'd0;
		end else begin
			if (ob_push) ob_mem[ob_wp_q] <= ob_in;
			if (ob_push) ob_wp_q <= !ob_wp_q;
			if (ob_pop) ob_rp_q <= !ob_rp_q;
			ob_cnt_q <= ob_cnt_q + 2'(ob_push) - 2'(ob_pop);
		end
	end

	// checks
	a_lb_cs_width: assert property (@(posedge core_clk) disable iff (!nrst)
		$fell(phy_local_chip_select_n) |-> !phy_local_chip_select_n [*8] ##1 phy_local_chip_select_n)
		else $error("chip select width wrong");
	a_burst_size: assert property (@(posedge core_clk) disable iff (!nrst)
		host_xfer_req |-> host_xfer_words == ($past(host_tx_misaligned) ? 4'd13 : 4'd12))
		else $error("burst word count wrong");
	a_rx_depth_latency: assert property (@(posedge core_clk) disable iff (!nrst)
		RX_CELLS >= LAT_CELLS) else $error("receive buffer too shallow");
	a_rx_vci_range: assert property (@(posedge core_clk) disable iff (!nrst)
		rxf_wr && rxp == 6'd3 |-> rx_sh_d[19:4] <= 16'h03ff && rx_sh_d[31:4] != '0)
		else $error("bad header stored");
	a_cm_priority: assert property (@(posedge core_clk) disable iff (!nrst)
		$rose(cm_act_q) |-> gnt_q == first_req($past(req_vec)) ##1 cm_done_q == (6'h01 << gnt_q))
		else $error("grant order wrong");
	a_cm_read_strobe: assert property (@(posedge core_clk) disable iff (!nrst)
		$fell(ctrl_mem_output_enable_n) |-> ctrl_mem_write_strobe_n ##1 ctrl_mem_output_enable_n
		&& cm_rd_q == $past(ctrl_mem_data_in))
		else $error("read strobe wrong");
	a_tx_crc_append: assert property (@(posedge core_clk) disable iff (!nrst)
		txf_wr && tx_st_q == T_DATA && tx_crc_word |-> txf_wdata.data == tx_crc_q)
		else $error("crc not appended");
	a_tx_buf_bound: assert property (@(posedge core_clk) disable iff (!nrst)
		tx_cnt_q <= TXA'(TX_DEPTH) && !(txf_wr && tx_cnt_q == TXA'(TX_DEPTH)))
		else $error("transmit buffer overrun");
	a_tx_soc_header: assert property (@(posedge core_clk) disable iff (!nrst)
		tx_go && txb_q == '0 |-> tx_head.first ##1 tx_phy_soc && !tx_phy_enable_n)
		else $error("cell start not on header");
endmodule

// [testbench/sar_far_model.sv]
// far side model: asynchronous control memory, 16k words of 32 bits
// assumes active-low strobes registered by the core in the same cycle as address and data
module sar_far_model import atm_sar_pkg::*; (
	// memory pins
	input wire logic [CM_AW-1:0] ctrl_mem_address,
	input wire logic [WORD_W-1:0] ctrl_mem_data_out,
	input wire logic ctrl_mem_data_oe,
	input wire logic ctrl_mem_output_enable_n,
	input wire logic ctrl_mem_write_strobe_n,
	output logic [WORD_W-1:0] ctrl_mem_data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [WORD_W-1:0] mem [0:16383];
	logic [WORD_W-1:0] last_q;
	// cleared array so every bandwidth slot starts invalid
	initial begin
		foreach (mem[i]) mem[i] = '0;
		last_q = '0;
	end
	// word stored as the strobe rises; an undriven bus stores garbage
	always @(posedge ctrl_mem_write_strobe_n) begin
		mem[ctrl_mem_address] <= ctrl_mem_data_oe ? ctrl_mem_data_out : ~ctrl_mem_data_out;
	end
	// read data only while output enable is low, inverted junk otherwise
	always @(posedge ctrl_mem_output_enable_n) last_q <= mem[ctrl_mem_address];
	assign ctrl_mem_data_in = ctrl_mem_output_enable_n ? ~last_q : mem[ctrl_mem_address];
endmodule

// [testbench/atm_cell_sar_core_tb_top.sv]
// bench for the cell core: memory arbiter, local bus, idle cells, receive reassembly, host transfers
// assumes the far side model is the only memory and aal3/4 mode so no packet check is needed
module atm_cell_sar_core_tb_top import atm_sar_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, nrst, host_tx_pending, host_tx_last, host_tx_misaligned, host_tx_valid, host_tx_ready;
	logic host_xfer_req, aal34_mode, rx_host_ready, rx_host_valid, ctrl_mem_data_oe, ctrl_mem_output_enable_n;
	logic ctrl_mem_write_strobe_n, lb_wr_valid, lb_wr_ready, phy_local_chip_select_n;
	logic tx_phy_full_n, tx_phy_soc, tx_phy_enable_n;
	logic [WORD_W-1:0] host_tx_data, cm_rd_data, ctrl_mem_data_in, ctrl_mem_data_out;
	logic [3:0] host_xfer_words;
	logic [2:0] ext_cm_req, ext_cm_done;
	logic [CM_AW-1:0] ctrl_mem_address;
	logic [15:0] lb_wr_addr, lb_addr;
	logic [7:0] lb_wr_data, lb_data, tx_phy_data;
	rx_out_t rx_host_out;
	cm_req_t ext_cm_rxh, ext_cm_txh, ext_cm_brg;
	phy_rx_pins_t rx_phy_pins;
	rx_out_t rxq[$];
	int failures, checks;
	atm_cell_sar_core i_dut (.core_clk, .nrst, .host_tx_pending, .host_tx_last, .host_tx_misaligned,
		.host_tx_valid, .host_tx_data, .host_tx_ready, .host_xfer_req, .host_xfer_words, .aal34_mode,
		.rx_host_ready, .rx_host_valid, .rx_host_out, .ext_cm_req, .ext_cm_rxh, .ext_cm_txh, .ext_cm_brg,
		.ext_cm_done, .cm_rd_data, .ctrl_mem_address, .ctrl_mem_data_in, .ctrl_mem_data_out,
		.ctrl_mem_data_oe, .ctrl_mem_output_enable_n, .ctrl_mem_write_strobe_n, .lb_wr_valid, .lb_wr_addr,
		.lb_wr_data, .lb_wr_ready, .phy_local_chip_select_n, .lb_addr, .lb_data, .tx_phy_full_n,
		.tx_phy_data, .tx_phy_soc, .tx_phy_enable_n, .rx_phy_pins);
	sar_far_model i_mem (.ctrl_mem_address, .ctrl_mem_data_out, .ctrl_mem_data_oe,
		.ctrl_mem_output_enable_n, .ctrl_mem_write_strobe_n, .ctrl_mem_data_in);
	// clock
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// words handed to the host side
	always @(posedge core_clk) if (rx_host_valid === 1'b1 && rx_host_ready === 1'b1) rxq.push_back(rx_host_out);
	task automatic give_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic step(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// one memory word through requester k, held until its done pulse
	task automatic cm(int k, logic we, logic [CM_AW-1:0] a, logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		if (k == 0) ext_cm_rxh = {we, a, d};
		else if (k == 1) ext_cm_txh = {we, a, d};
		else ext_cm_brg = {we, a, d};
		ext_cm_req[k] = 1'b1;
		while (ext_cm_done[k] !== 1'b1 && n < 300) begin
			step(1);
			n++;
		end
		q = cm_rd_data;
		ext_cm_req[k] = 1'b0;
		chk("memory done", 1, ext_cm_done[k]);
		step(1);
	endtask
	task automatic cm_test();
		logic [31:0] q;
		int n;
		cm(1, 1'b1, 14'h3ff0, 32'h5a3c0f96, q);
		cm(2, 1'b0, 14'h3ff0, 32'h0, q);
		chk("memory read", 32'h5a3c0f96, q);
		n = 0;
		ext_cm_req = 3'b101;
		while (ext_cm_done === 3'b000 && n < 300) begin
			step(1);
			n++;
		end
		chk("first grant", 32'h1, {29'h0, ext_cm_done});
		ext_cm_req[0] = 1'b0;
		while (ext_cm_done[2] !== 1'b1 && n < 600) begin
			step(1);
			n++;
		end
		chk("later grant", 1, ext_cm_done[2]);
		ext_cm_req[2] = 1'b0;
		step(1);
	endtask
	// one byte write, then count chip select low cycles
	task automatic lb_test();
		int lo;
		lo = 0;
		lb_wr_addr = 16'hbeef;
		lb_wr_data = 8'ha5;
		lb_wr_valid = 1'b1;
		step(1);
		lb_wr_valid = 1'b0;
		repeat (12) begin
			if (phy_local_chip_select_n === 1'b0) lo++;
			step(1);
		end
		chk("select low cycles", 8, lo);
		chk("local address", 16'hbeef, lb_addr);
		chk("local data", 8'ha5, lb_data);
		chk("local ready", 1, lb_wr_ready);
	endtask
	// idle cell on the phy, then a stall by the phy
	task automatic tx_idle();
		logic [8:0] b[$];
		int n, hi;
		n = 0;
		hi = 0;
		while (!(tx_phy_soc === 1'b1 && tx_phy_enable_n === 1'b0) && n < 3000) begin
			step(1);
			n++;
		end
		while (b.size() < 54 && n < 6000) begin
			if (tx_phy_enable_n === 1'b0) b.push_back({tx_phy_soc, tx_phy_data});
			step(1);
			n++;
		end
		chk("idle header", IDLE_HDR, {b[0][7:0], b[1][7:0], b[2][7:0], b[3][7:0]});
		chk("fill byte", HEC_FILL, b[4][7:0]);
		chk("cell length", 2, {b[53][8], b[52][8]});
		tx_phy_full_n = 1'b0;
		step(6);
		repeat (4) begin
			if (tx_phy_enable_n === 1'b1) hi++;
			step(1);
		end
		chk("stalled enable", 4, hi);
		tx_phy_full_n = 1'b1;
	endtask
	// byte on the slow phy clock
	task automatic rx_byte(logic [7:0] v, logic s);
		rx_phy_pins = '{clk: 1'b0, soc: s, empty_n: 1'b1, data: v};
		step(4);
		rx_phy_pins.clk = 1'b1;
		step(4);
	endtask
	task automatic rx_cell(logic [15:0] vci, logic [7:0] s);
		logic [31:0] h;
		h = {12'h000, vci, 4'h0};
		for (int i = 0; i < CELL_BYTES; i++) rx_byte(i < 4 ? h[31-8*i -: 8] : (i == 4 ? 8'h00 : 8'(s + i - 5)), i == 0);
		rx_phy_pins = '{clk: 1'b0, soc: 1'b0, empty_n: 1'b0, data: ~rx_phy_pins.data};
	endtask
	task automatic rx_test();
		logic [31:0] q, e;
		logic [7:0] s;
		int n;
		n = 0;
		cm(2, 1'b1, RX_DMA_BASE + 14'd37, 32'hffffffff, q);
		rx_host_ready = 1'b0;
		rx_cell(16'h0000, 8'h20);
		rx_cell(16'h07d0, 8'h20);
		rx_cell(16'h0025, 8'h10);
		rx_cell(16'h0025, 8'h40);
		step(10);
		rx_host_ready = 1'b1;
		while (rxq.size() < 24 && n < 500) begin
			step(1);
			n++;
		end
		step(20);
		chk("words passed", 24, rxq.size());
		for (int i = 0; i < 24 && i < rxq.size(); i++) begin
			s = i < 12 ? 8'h10 : 8'h40;
			e = {8'(s + 4 * (i % 12)), 8'(s + 4 * (i % 12) + 1), 8'(s + 4 * (i % 12) + 2), 8'(s + 4 * (i % 12) + 3)};
			chk("rx word", e, rxq[i].data);
			chk("rx circuit", 37, rxq[i].vci);
			chk("rx end", i == 23, rxq[i].last);
			chk("rx check", 1, rxq[i].crc_ok);
		end
	endtask
	// two scheduled cells: aligned then misaligned
	task automatic tx_host();
		logic [31:0] q;
		int n, g;
		// two adjacent slots well ahead of where the table walk stands now
		cm(2, 1'b1, BWG_BASE + 14'h0080, 32'h80000005, q);
		cm(2, 1'b1, BWG_BASE + 14'h0081, 32'h80000005, q);
		host_tx_pending = 1'b1;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			g = 0;
			host_tx_misaligned = k[0];
			while (host_xfer_req !== 1'b1 && g < 40000) begin
				step(1);
				g++;
			end
			chk("burst words", 12 + k, host_xfer_words);
			host_tx_valid = 1'b1;
			host_tx_data = 32'h0;
			while (n < 12 && g < 40100) begin
				g++;
				if (host_tx_ready === 1'b1) n++;
				step(1);
				host_tx_data = 32'(n);
			end
			host_tx_valid = 1'b0;
			chk("ready after cell", 0, host_tx_ready);
		end
		host_tx_pending = 1'b0;
	endtask
	// watchdog
	initial begin
		repeat (95000) @(posedge core_clk);
		failures++;
		give_verdict();
	end
	// main sequence
	initial begin
		{nrst, host_tx_pending, host_tx_last, host_tx_misaligned, host_tx_valid, lb_wr_valid} = '0;
		{host_tx_data, lb_wr_addr, lb_wr_data, ext_cm_req} = '0;
		{ext_cm_rxh, ext_cm_txh, ext_cm_brg, rx_phy_pins} = '0;
		aal34_mode = 1'b1;
		rx_host_ready = 1'b1;
		tx_phy_full_n = 1'b1;
		step(5);
		nrst = 1'b1;
		step(2);
		cm_test();
		lb_test();
		tx_idle();
		rx_test();
		tx_host();
		give_verdict();
	end
endmodule
